// *** rtl/profile_timeout_pkg.sv ***
// Constants for the charger profile enable and timeout register bank.
package profile_timeout_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_LEGACY_DISABLE = 8'h21;
  localparam logic [7:0] ADDR_DCP_TIMEOUT = 8'h22;
  localparam logic [7:0] ADDR_LEGACY_TIMEOUT_LO = 8'h23;
  localparam logic [7:0] ADDR_LEGACY_TIMEOUT_HI = 8'h24;

  // ==========================================================
  // Reset values and implemented-bit masks
  localparam logic [7:0] RST_LEGACY_DISABLE = 8'h00;
  localparam logic [7:0] RST_DCP_TIMEOUT = 8'h10;
  localparam logic [7:0] RST_LEGACY_TIMEOUT_LO = 8'h6c;
  localparam logic [7:0] RST_LEGACY_TIMEOUT_HI = 8'h01;
  localparam logic [7:0] MASK_LEGACY_DISABLE = 8'h7f;
  localparam logic [7:0] MASK_DCP_TIMEOUT = 8'h3f;
  localparam logic [7:0] MASK_LEGACY_TIMEOUT_LO = 8'hff;
  localparam logic [7:0] MASK_LEGACY_TIMEOUT_HI = 8'h3f;

  // ==========================================================
  // Field positions
  localparam int DCP_SEL_LSB = 4;
  localparam int NUM_LEGACY = 7;

  // ==========================================================
  // Applied profile codes
  localparam logic [3:0] PROFILE_DCP = 4'h2;
  localparam logic [3:0] PROFILE_LEGACY1 = 4'h3;
  localparam logic [3:0] PROFILE_LEGACY7 = 4'h9;

  // ==========================================================
  // Timeout choices in milliseconds and the clock rate
  localparam int unsigned TIME_SEL0_MS = 800;
  localparam int unsigned TIME_SEL1_MS = 1600;
  localparam int unsigned TIME_SEL2_MS = 6400;
  localparam int unsigned TIME_SEL3_MS = 12800;
  localparam int unsigned CLK_CYCLES_PER_MS = 25000;
  localparam int LIMIT_W = 29;

endpackage

// *** rtl/charger_profile_enable_timeout.sv ***
// Legacy profile disable bits and per-profile emulation timeout selectors.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - Bits 0-6 disable legacy profiles 1-7.
// RULE2 - Cleared disable bit lets profile join cycling.
// RULE3 - Applied profile uses its configured time limit.
// RULE4 - Global disable ignores all timeout selectors.
// RULE5 - Timeout registers keep contents during sleep.
// RULE6 - 0x22 bits 5-4 select dedicated port timeout.
// RULE7 - 0x23 holds legacy 1-4 timeout selectors.
// RULE8 - Software preserves reserved low nibble of 0x22.
// RULE9 - 0x24 holds legacy 5-7 timeout selectors.
module charger_profile_enable_timeout
  import profile_timeout_pkg::*;
#(
  parameter logic [LIMIT_W-1:0] TIME_SEL0_CYC =
    LIMIT_W'(TIME_SEL0_MS * CLK_CYCLES_PER_MS),
  parameter logic [LIMIT_W-1:0] TIME_SEL1_CYC =
    LIMIT_W'(TIME_SEL1_MS * CLK_CYCLES_PER_MS),
  parameter logic [LIMIT_W-1:0] TIME_SEL2_CYC =
    LIMIT_W'(TIME_SEL2_MS * CLK_CYCLES_PER_MS),
  parameter logic [LIMIT_W-1:0] TIME_SEL3_CYC =
    LIMIT_W'(TIME_SEL3_MS * CLK_CYCLES_PER_MS)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port from the management interface
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  // Emulation cycle status
  input wire logic dce_active_i,
  input wire logic [3:0] applied_profile_i,
  input wire logic global_timeout_disable_i,
  // Configuration toward the sequencer
  output logic [NUM_LEGACY-1:0] legacy_enable_o,
  output logic [7:0][1:0] timeout_sel_o,
  output logic profile_time_limit_en_o,
  output logic [LIMIT_W-1:0] profile_time_limit_o
);

  // ==========================================================
  // Storage
  logic [7:0] legacy_disable_r;
  logic [7:0] dcp_timeout_r;
  logic [7:0] legacy_lo_r;
  logic [7:0] legacy_hi_r;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic [7:0][1:0] sel;
  logic [1:0] cur_sel;
  logic cur_valid;
  logic [LIMIT_W-1:0] limit_nxt;

  // ==========================================================
  // Register writes
  // Only power-on reset clears these; sleep has no path to them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      legacy_disable_r <= RST_LEGACY_DISABLE; // RULE5
    end else if (wr_en_i && addr_i == ADDR_LEGACY_DISABLE) begin
      legacy_disable_r <= wr_data_i & MASK_LEGACY_DISABLE; // RULE1
    end
  end

  // The low nibble is stored as written and read back, so a
  // read-modify-write by software keeps it intact.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dcp_timeout_r <= RST_DCP_TIMEOUT; // RULE5
    end else if (wr_en_i && addr_i == ADDR_DCP_TIMEOUT) begin
      dcp_timeout_r <= wr_data_i & MASK_DCP_TIMEOUT; // RULE8
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      legacy_lo_r <= RST_LEGACY_TIMEOUT_LO; // RULE5
    end else if (wr_en_i && addr_i == ADDR_LEGACY_TIMEOUT_LO) begin
      legacy_lo_r <= wr_data_i & MASK_LEGACY_TIMEOUT_LO; // RULE7
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      legacy_hi_r <= RST_LEGACY_TIMEOUT_HI; // RULE5
    end else if (wr_en_i && addr_i == ADDR_LEGACY_TIMEOUT_HI) begin
      legacy_hi_r <= wr_data_i & MASK_LEGACY_TIMEOUT_HI; // RULE9
    end
  end

  // ==========================================================
  // Read back
  always_comb begin
    rd_data_nxt = 8'h00;
    if (addr_i == ADDR_LEGACY_DISABLE) begin
      rd_data_nxt = legacy_disable_r;
    end else if (addr_i == ADDR_DCP_TIMEOUT) begin
      rd_data_nxt = dcp_timeout_r;
    end else if (addr_i == ADDR_LEGACY_TIMEOUT_LO) begin
      rd_data_nxt = legacy_lo_r;
    end else if (addr_i == ADDR_LEGACY_TIMEOUT_HI) begin
      rd_data_nxt = legacy_hi_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_r <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_o = rd_data_r;

  // ==========================================================
  // Selector fields: entry 0 is the dedicated port, 1-7 legacy
  assign sel[0] = dcp_timeout_r[DCP_SEL_LSB +: 2]; // RULE6
  genvar g;
  for (g = 1; g <= NUM_LEGACY; g++) begin : g_legacy
    if (g <= 4) begin : g_lo
      assign sel[g] = legacy_lo_r[8-2*g +: 2]; // RULE7
    end else begin : g_hi
      assign sel[g] = legacy_hi_r[14-2*g +: 2]; // RULE9
    end
  end

  // ==========================================================
  // Time limit of the profile being applied
  always_comb begin
    cur_sel = 2'h0;
    cur_valid = 1'b0;
    if (applied_profile_i == PROFILE_DCP) begin
      cur_sel = sel[0];
      cur_valid = 1'b1;
    end else if (applied_profile_i >= PROFILE_LEGACY1 &&
                 applied_profile_i <= PROFILE_LEGACY7) begin
      cur_sel = sel[3'(applied_profile_i - PROFILE_DCP)];
      cur_valid = 1'b1;
    end
    case (cur_sel)
      2'h0: limit_nxt = TIME_SEL0_CYC;
      2'h1: limit_nxt = TIME_SEL1_CYC;
      2'h2: limit_nxt = TIME_SEL2_CYC;
      default: limit_nxt = TIME_SEL3_CYC; // RULE6
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      profile_time_limit_en_o <= 1'b0;
      profile_time_limit_o <= TIME_SEL0_CYC;
    end else begin
      profile_time_limit_en_o <= dce_active_i && cur_valid &&
                                 !global_timeout_disable_i; // RULE3 RULE4
      profile_time_limit_o <= limit_nxt; // RULE3
    end
  end

  // ==========================================================
  // Configuration outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      legacy_enable_o <= ~RST_LEGACY_DISABLE[NUM_LEGACY-1:0];
    end else begin
      legacy_enable_o <= ~legacy_disable_r[NUM_LEGACY-1:0]; // RULE2
    end
  end

  // The sequencer sees the selectors one cycle after a write lands.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_sel_o <= '0;
    end else begin
      timeout_sel_o <= sel;
    end
  end

endmodule

`default_nettype wire

// *** test/profile_timeout_properties.sv ***
// Port-level properties of the profile timeout register bank.
`timescale 1ns/1ps
`default_nettype none
module profile_timeout_props
  import profile_timeout_pkg::*;
#(
  parameter logic [LIMIT_W-1:0] TIME_SEL0_CYC = 8, TIME_SEL1_CYC = 16,
  parameter logic [LIMIT_W-1:0] TIME_SEL2_CYC = 64, TIME_SEL3_CYC = 128
) (
  // Watched ports.
  input wire logic clk_i, rst_n_i, wr_en_i, rd_en_i,
  input wire logic [7:0] addr_i, wr_data_i, rd_data_o,
  input wire logic dce_active_i, global_timeout_disable_i,
  input wire logic [3:0] applied_profile_i,
  input wire logic [NUM_LEGACY-1:0] legacy_enable_o,
  input wire logic [7:0][1:0] timeout_sel_o,
  input wire logic profile_time_limit_en_o,
  input wire logic [LIMIT_W-1:0] profile_time_limit_o
);
  // ====
  // Properties.
  logic [2:0] k;
  logic act;
  logic [LIMIT_W-1:0] cyc [4];
  assign k = 3'(applied_profile_i - 4'h2);
  assign act = dce_active_i && applied_profile_i inside {[4'h2:4'h9]};
  assign cyc = '{TIME_SEL0_CYC, TIME_SEL1_CYC, TIME_SEL2_CYC, TIME_SEL3_CYC};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr_at(logic [7:0] a); wr_en_i && addr_i == a; endsequence
  // Selectors are only trusted once no write is in flight.
  sequence settled; $past(rst_n_i) && !wr_en_i && !$past(wr_en_i); endsequence
  a_disable_bits: assert property (wr_at(8'h21) |-> ##2
    legacy_enable_o == ~$past(wr_data_i[6:0], 2)) else $error("disable");
  a_dcp_select: assert property (wr_at(8'h22) |-> ##2
    timeout_sel_o[0] == $past(wr_data_i[5:4], 2)) else $error("dcp sel");
  a_legacy_lo: assert property (wr_at(8'h23) |-> ##2
    {timeout_sel_o[1], timeout_sel_o[2], timeout_sel_o[3],
     timeout_sel_o[4]} == $past(wr_data_i, 2)) else $error("lo sel");
  a_legacy_hi: assert property (wr_at(8'h24) |-> ##2
    {timeout_sel_o[5], timeout_sel_o[6], timeout_sel_o[7]}
    == $past(wr_data_i[5:0], 2)) else $error("hi sel");
  a_global_off: assert property (global_timeout_disable_i |=>
    !profile_time_limit_en_o) else $error("limit not off");
  a_limit_on: assert property (act && !global_timeout_disable_i |=>
    profile_time_limit_en_o) else $error("limit not on");
  a_limit_value: assert property (act ##0 settled |=>
    profile_time_limit_o == $past(cyc[timeout_sel_o[k]])) else $error("lim");
  a_unimpl_bits: assert property (rd_en_i &&
    addr_i inside {8'h21, 8'h24} |=> !rd_data_o[7]) else $error("bit 7");
endmodule
bind charger_profile_enable_timeout profile_timeout_props #(
  .TIME_SEL0_CYC(TIME_SEL0_CYC), .TIME_SEL1_CYC(TIME_SEL1_CYC),
  .TIME_SEL2_CYC(TIME_SEL2_CYC), .TIME_SEL3_CYC(TIME_SEL3_CYC)
) i_profile_timeout_props (.*);
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the profile timeout register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module tb;
  import profile_timeout_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr_en_i = 0, rd_en_i = 0;
  logic [7:0] addr_i = 0, wr_data_i = 0, rd_data_o;
  logic dce_active_i = 0, global_timeout_disable_i = 0;
  logic [3:0] applied_profile_i = 0;
  logic [NUM_LEGACY-1:0] legacy_enable_o;
  logic [7:0][1:0] timeout_sel_o;
  logic profile_time_limit_en_o;
  logic [LIMIT_W-1:0] profile_time_limit_o;
  int mismatches = 0, num_checks = 0;
  logic [31:0] seed = 32'h8de6;
  logic [7:0] sh [4] = '{RST_LEGACY_DISABLE, RST_DCP_TIMEOUT,
    RST_LEGACY_TIMEOUT_LO, RST_LEGACY_TIMEOUT_HI};
  logic [7:0] msk [4] = '{MASK_LEGACY_DISABLE, MASK_DCP_TIMEOUT,
    MASK_LEGACY_TIMEOUT_LO, MASK_LEGACY_TIMEOUT_HI};
  // Short counts keep the run brief; expectations follow them.
  logic [LIMIT_W-1:0] cy [4] = '{8, 16, 64, 128};
  logic [7:0] rq [$];
  logic [29:0] lq [$];
  logic [15:0] s16;
  charger_profile_enable_timeout #(.TIME_SEL0_CYC(8), .TIME_SEL1_CYC(16),
    .TIME_SEL2_CYC(64), .TIME_SEL3_CYC(128))
    i_charger_profile_enable_timeout (.*);
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ====
  // Drivers: each notes its expected result for the monitor.
  task automatic op(input logic w, r, input logic [7:0] a, d);
    @(posedge clk_i);
    #1;
    {wr_en_i, rd_en_i, addr_i, wr_data_i} = {w, r, a, d};
    if (r) rq.push_back(a inside {[8'h21:8'h24]} ? sh[a-8'h21] : 8'h00);
    if (w && a inside {[8'h21:8'h24]}) sh[a-8'h21] = d & msk[a-8'h21];
  endtask
  task automatic lim(input logic [3:0] p, input logic dce, g);
    @(posedge clk_i);
    #1;
    {wr_en_i, rd_en_i} = 2'b00;
    {dce_active_i, applied_profile_i, global_timeout_disable_i} = {dce, p, g};
    s16 = {sh[1][5:4], sh[2], sh[3][5:0]};
    lq.push_back({dce && !g && p inside {[4'h2:4'h9]},
      cy[s16[15-2*(p-4'h2) -: 2]]});
  endtask
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    logic [29:0] m;
    #0.5;
    if (rq.size()) begin
      m = 30'(rq.pop_front());
      `CHK(rd_data_o, m[7:0])
    end
    if (lq.size()) begin
      m = lq.pop_front();
      `CHK(profile_time_limit_en_o, m[29])
      if (m[29]) `CHK(profile_time_limit_o, m[28:0])
    end
  end
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1;
    for (int i = 0; i < 6; i++) op(0, 1, 8'h20 + 8'(i), 0);
    for (int i = 0; i < 30; i++) begin
      a = 8'h21 + 8'(i % 5);
      d = 8'(xs());
      if (a == ADDR_DCP_TIMEOUT) d[3:0] = sh[1][3:0];
      op(1, 0, a, d);
      d = 8'(xs());
      if (a == ADDR_DCP_TIMEOUT) d[3:0] = sh[1][3:0];
      op(i[0], 1, a, d);
      op(0, 1, a, 0);
      lim(4'(1 + i % 10), 1'(i % 7 != 0), i[1] & i[2]);
    end
    repeat (3) @(posedge clk_i);
    test_done();
  end
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
